// File: design/i2c_port_alias_indirect_access.sv
// What this block does
// RULE1 - Ports 1 to 3 each have an alias register holding a 7-bit target address.
// RULE2 - An alias field of zero disables that port's decoder entirely.
// RULE3 - Alias hits reach that port's registers without paging, plus all shared registers.
// RULE4 - Indirect block select, offset and data registers sit at 0xB0 to 0xB2.
// RULE5 - Block select chooses which internal register block indirect accesses reach.
// RULE6 - Indirect write: select, offset, then data write stores byte at offset.
// RULE7 - Indirect read: select, offset, then data read returns byte at offset.
// RULE8 - With auto-increment on, each data access advances the offset by one.
// RULE9 - Host sets block and offset before each new indirect write sequence.
// RULE10 - Port 0 also has an alias register laid out like the others.
// RULE11 - Main-address accesses reach the port chosen by the port select register.
// RULE12 - Alias bit 0 is reserved, reads zero and ignores writes.
`timescale 1ns/1ns
module i2c_port_alias_indirect_access (
	input wire logic clk,
	input wire logic reset,
	input wire logic mainHit,
	input wire logic [6:0] targetAddr,
	input wire logic accValid,
	input wire logic accWrite,
	input wire logic [7:0] accOffset,
	input wire logic [7:0] accWdata,
	input wire logic [7:0] portSelect,
	input wire logic [7:0] extRdata,
	input wire logic [7:0] indRdata,
	output logic accAck,
	output logic [7:0] accRdata,
	output logic [1:0] accessPort,
	output logic accessPortValid,
	output logic extValid,
	output logic extWrite,
	output logic [7:0] extOffset,
	output logic [7:0] extWdata,
	output logic indValid,
	output logic indWrite,
	output logic [2:0] indBlock,
	output logic [7:0] indOffset,
	output logic [7:0] indWdata
);

	// All state of the block, registered as one word
	typedef struct packed {
		logic [3:0][7:0] aliasReg;
		logic [7:0] blockSel;
		logic [7:0] offset;
		logic ack;
		logic [7:0] rdata;
		logic [1:0] port;
		logic portValid;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Decode and routing signals
	logic [3:0] aliasMatch;
	logic aliasHit;
	logic [1:0] aliasPort;
	logic routeValid;
	logic [1:0] routePort;
	logic isLocal;
	logic isIndData;
	logic isBlockSel;
	logic isOffsetReg;
	logic accept;
	logic [3:0] aliasWe;
	logic [7:0] readByte;
	logic autoInc;
	logic [7:0] bumpedOffset;
	logic [1:0] aliasIdx;

	// Offset of an alias register, or none
	function automatic logic aliasOfs(input logic [7:0] ofs);
		aliasOfs = (ofs >= alias_access_pkg::PORT0_I2C_ALIAS_OFS) &&
			(ofs <= alias_access_pkg::PORT3_I2C_ALIAS_OFS);
	endfunction : aliasOfs

	// Offset of the indirect block select register
	function automatic logic blockSelOfs(input logic [7:0] ofs);
		blockSelOfs = ofs == alias_access_pkg::INDIRECT_BLOCK_SELECT_OFS;
	endfunction : blockSelOfs

	// Offset of the indirect offset register
	function automatic logic offsetOfs(input logic [7:0] ofs);
		offsetOfs = ofs == alias_access_pkg::INDIRECT_OFFSET_OFS;
	endfunction : offsetOfs

	// Offset of the indirect data window
	function automatic logic dataOfs(input logic [7:0] ofs);
		dataOfs = ofs == alias_access_pkg::INDIRECT_DATA_PORT_OFS;
	endfunction : dataOfs

	////////////////////////////////////////////////////////////////////////////
	// Per-port alias decoders
	genvar g;
	generate
		for (g = 0; g < alias_access_pkg::NUM_PORTS; g++) begin : gDecode
			assign aliasMatch[g] = (s_q.aliasReg[g][7:1] != 7'h00) && // RULE2
				(s_q.aliasReg[g][7:1] == targetAddr); // RULE1 RULE10
			assign aliasWe[g] = accept && accWrite && aliasOfs(accOffset) &&
				(aliasIdx == 2'(g));
		end
	endgenerate

	// Lowest matching port wins on overlap
	always_comb begin
		aliasHit = 1'b0;
		aliasPort = 2'd0;
		for (int i = alias_access_pkg::NUM_PORTS - 1; i >= 0; i--) begin
			if (aliasMatch[i]) begin
				aliasHit = 1'b1;
				aliasPort = i[1:0];
			end
		end
	end

	// Port routing: alias bypasses paging, main address uses port select
	always_comb begin
		routeValid = 1'b0;
		routePort = 2'd0;
		if (aliasHit) begin
			routeValid = 1'b1; // RULE3
			routePort = aliasPort;
		end else if (mainHit) begin
			routeValid = 1'b1;
			routePort = portSelect[1:0]; // RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Local register decode
	assign isIndData = dataOfs(accOffset); // RULE4
	assign isBlockSel = blockSelOfs(accOffset); // RULE4
	assign isOffsetReg = offsetOfs(accOffset); // RULE4
	assign isLocal = aliasOfs(accOffset) || isIndData || isBlockSel || isOffsetReg;

	// An access is taken only when some decoder claims the transaction
	assign accept = accValid && routeValid;

	// Alias registers sit four in a row from the port 0 offset
	assign aliasIdx = accOffset[1:0] - alias_access_pkg::PORT0_I2C_ALIAS_OFS[1:0];

	// Offset after a data window access; wraps from 0xFF back to 0
	assign autoInc = s_q.blockSel[alias_access_pkg::AUTO_INC_BIT];
	assign bumpedOffset = s_q.offset + 8'h01; // RULE8

	// Read data mux over the local registers and both outside sources
	always_comb begin
		readByte = extRdata;
		if (aliasOfs(accOffset)) begin
			readByte = s_q.aliasReg[aliasIdx]; // RULE12
		end else if (isBlockSel) begin
			readByte = s_q.blockSel;
		end else if (isOffsetReg) begin
			readByte = s_q.offset;
		end else if (isIndData) begin
			readByte = indRdata; // RULE7
		end
	end

	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		if (accept) begin
			s_d.ack = 1'b1;
			s_d.port = routePort;
			s_d.portValid = 1'b1;
			if (!accWrite) begin
				s_d.rdata = readByte;
			end
			if (accWrite && isBlockSel) begin
				s_d.blockSel = accWdata; // RULE5
			end
			if (accWrite && isOffsetReg) begin
				s_d.offset = accWdata; // RULE9
			end
			// With auto-increment set, bump follows every data window access, read or write
			if (isIndData && autoInc) begin
				s_d.offset = bumpedOffset; // RULE8
			end
		end
		// Alias writes keep the reserved bit 0 clear
		for (int p = 0; p < alias_access_pkg::NUM_PORTS; p++) begin
			if (aliasWe[p]) begin
				s_d.aliasReg[p] = accWdata & alias_access_pkg::ALIAS_WRITE_MASK; // RULE12
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q.aliasReg <= {alias_access_pkg::NUM_PORTS{alias_access_pkg::ALIAS_RESET}};
			s_q.blockSel <= alias_access_pkg::BLOCK_SELECT_RESET;
			s_q.offset <= alias_access_pkg::OFFSET_RESET;
			s_q.ack <= 1'b0;
			s_q.rdata <= 8'h00;
			s_q.port <= 2'd0;
			s_q.portValid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strobes to the indirect blocks and the rest of the register map
	assign indValid = accept && isIndData; // RULE6 RULE7
	assign indWrite = accWrite;
	assign indBlock = s_q.blockSel[alias_access_pkg::BLOCK_ID_LSB +: alias_access_pkg::BLOCK_ID_WIDTH];
	assign indOffset = s_q.offset; // RULE6
	assign indWdata = accWdata;

	// Outward strobes for registers kept elsewhere in the map
	assign extValid = accept && !isLocal; // RULE3
	assign extWrite = accWrite;
	assign extOffset = accOffset;
	assign extWdata = accWdata;

	// Answer outputs
	assign accAck = s_q.ack;
	assign accRdata = s_q.rdata;
	assign accessPort = s_q.port;
	assign accessPortValid = s_q.portValid;

endmodule : i2c_port_alias_indirect_access

// File: design/alias_access_pkg.sv
package alias_access_pkg;
	// Main register space offsets
	localparam logic [7:0] PORT_SELECT_OFS = 8'h4C;
	localparam logic [7:0] INDIRECT_BLOCK_SELECT_OFS = 8'hB0;
	localparam logic [7:0] INDIRECT_OFFSET_OFS = 8'hB1;
	localparam logic [7:0] INDIRECT_DATA_PORT_OFS = 8'hB2;
	localparam logic [7:0] PORT0_I2C_ALIAS_OFS = 8'hF8;
	localparam logic [7:0] PORT1_I2C_ALIAS_OFS = 8'hF9;
	localparam logic [7:0] PORT2_I2C_ALIAS_OFS = 8'hFA;
	localparam logic [7:0] PORT3_I2C_ALIAS_OFS = 8'hFB;
	// Reset values
	localparam logic [7:0] ALIAS_RESET = 8'h00;
	localparam logic [7:0] BLOCK_SELECT_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h00;
	// Block select fields
	localparam int BLOCK_ID_LSB = 2;
	localparam int BLOCK_ID_WIDTH = 3;
	localparam int AUTO_INC_BIT = 1;
	// Alias layout: address in bits 7:1, bit 0 reserved
	localparam logic [7:0] ALIAS_WRITE_MASK = 8'hFE;
	localparam int NUM_PORTS = 4;
endpackage : alias_access_pkg

// File: dv/alias_access_props.sv
`timescale 1ns/1ns
module alias_access_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic mainHit,
	input wire logic [6:0] targetAddr,
	input wire logic accValid,
	input wire logic accWrite,
	input wire logic [7:0] accOffset,
	input wire logic [7:0] accWdata,
	input wire logic [7:0] portSelect,
	input wire logic [7:0] indRdata,
	input wire logic accAck,
	input wire logic [7:0] accRdata,
	input wire logic [1:0] accessPort,
	input wire logic indValid,
	input wire logic [2:0] indBlock,
	input wire logic [7:0] indOffset,
	input wire logic indWrite,
	input wire logic [7:0] indWdata,
	input wire logic extValid,
	input wire logic extWrite,
	input wire logic [7:0] extOffset,
	input wire logic [7:0] extWdata,
	input wire logic accessPortValid
);
	// Main access that no alias can claim
	wire mAcc = accValid & mainHit & (targetAddr == 7'h00);
	sequence dataWr;
		mAcc && accWrite && accOffset == 8'hB2;
	endsequence
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	chk_main_ack: assert property (mAcc |=> accAck) else $error("no ack");
	chk_zero_alias: assert property (accValid && !mainHit && targetAddr == 7'h00 |=> !accAck)
		else $error("zero alias acked");
	chk_ind_strobe: assert property (dataWr |-> indValid) else $error("no strobe");
	chk_block_set: assert property (mAcc && accWrite && accOffset == 8'hB0 |=>
		indBlock == 3'($past(accWdata) >> 2)) else $error("block");
	chk_offset_set: assert property (mAcc && accWrite && accOffset == 8'hB1 |=>
		indOffset == $past(accWdata)) else $error("offset");
	chk_offset_hold: assert property (!indValid && !(accValid && accOffset == 8'hB1) |=>
		$stable(indOffset)) else $error("offset moved");
	chk_ind_read: assert property (mAcc && !accWrite && accOffset == 8'hB2 |=>
		accRdata == $past(indRdata)) else $error("read");
	chk_main_port: assert property (mAcc |=> accessPort == $past(portSelect[1:0]))
		else $error("port");
	chk_ext_route: assert property (mAcc && accOffset == 8'h10 |->
		extValid && extOffset == 8'h10 && extWrite == accWrite && extWdata == accWdata)
		else $error("ext route");
	chk_ext_quiet: assert property (accValid && accOffset == 8'hB2 |-> !extValid)
		else $error("local leaked");
	chk_ind_copy: assert property (dataWr |-> indWrite && indWdata == accWdata)
		else $error("ind copy");
	chk_port_valid: assert property (mAcc |=> accessPortValid)
		else $error("port valid");
endmodule : alias_access_props

// File: dv/indirect_block_model.sv
`timescale 1ns/1ns
module indirect_block_model (
	input wire logic clk,
	input wire logic indValid,
	input wire logic indWrite,
	input wire logic [2:0] indBlock,
	input wire logic [7:0] indOffset,
	input wire logic [7:0] indWdata,
	output logic [7:0] indRdata,
	output logic [7:0] extRdata
);
	logic [7:0] mem [0:2047];
	// Each block keeps its own bytes
	always @(posedge clk) if (indValid && indWrite) mem[{indBlock, indOffset}] <= indWdata;
	assign indRdata = mem[{indBlock, indOffset}];
	assign extRdata = 8'hB5;
endmodule : indirect_block_model

// File: dv/i2c_port_alias_indirect_access_tb_top.sv
`timescale 1ns/1ns
module i2c_port_alias_indirect_access_tb_top;
	logic clk = 0, reset = 1, mainHit = 0, accValid = 0, accWrite = 0;
	logic [6:0] targetAddr = 0;
	logic [7:0] accOffset = 0, accWdata = 0, portSelect = 0, extRdata, indRdata, accRdata;
	logic [7:0] extOffset, extWdata, indOffset, indWdata;
	logic accAck, accessPortValid, extValid, extWrite, indValid, indWrite;
	logic [1:0] accessPort;
	logic [2:0] indBlock;
	int nErrors = 0, compares = 0, cyc = 0;
	i2c_port_alias_indirect_access dut (.*);
	indirect_block_model model (.*);
	initial forever #2 clk = ~clk;
	task cmp(input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// One byte access, answer sampled mid-cycle
	task xfer(input logic [6:0] t, input logic m, input logic w, input logic [7:0] o, d);
		@(posedge clk);
		mainHit <= m;
		targetAddr <= t;
		accWrite <= w;
		accOffset <= o;
		accWdata <= d;
		accValid <= 1;
		@(posedge clk);
		accValid <= 0;
		@(negedge clk);
	endtask : xfer
	task wr(input logic [6:0] t, input logic [7:0] o, d);
		xfer(t, t == 7'h00, 1, o, d);
		cmp(accAck, 1);
	endtask : wr
	task rd(input logic [6:0] t, input logic [7:0] o, e);
		xfer(t, t == 7'h00, 0, o, 0);
		cmp(accRdata, e);
	endtask : rd
	task wrapUp;
		if (nErrors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrapUp
	// Hang guard
	always @(posedge clk) if (++cyc == 3000) begin
		nErrors++;
		wrapUp;
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		for (int i = 0; i < 4; i++) begin
			rd(0, 8'hF8 + i, 0);
			wr(0, 8'hF8 + i, 8'h21 + 2 * i);
			rd(0, 8'hF8 + i, 8'h20 + 2 * i);
			@(posedge clk) portSelect <= 8'(3 - i);
			rd(7'h10 + i, 8'h10, 8'hB5);
			cmp(accessPort, i);
		end
		rd(0, 8'h10, 8'hB5);
		cmp(accessPort, 0);
		wr(0, 8'hF9, 0);
		xfer(7'h11, 0, 0, 8'h10, 0);
		cmp(accAck, 0);
		xfer(7'h00, 0, 0, 8'h10, 0);
		cmp(accAck, 0);
		wr(0, 8'hB0, 8'h0A);
		wr(0, 8'hB1, 8'h40);
		for (int i = 0; i < 3; i++) wr(0, 8'hB2, 8'h60 + i);
		cmp(indOffset, 8'h43);
		wr(0, 8'hB0, 8'h04);
		wr(0, 8'hB1, 8'h41);
		wr(0, 8'hB2, 8'h77);
		rd(0, 8'hB2, 8'h77);
		wr(0, 8'hB0, 8'h0A);
		wr(0, 8'hB1, 8'h40);
		for (int i = 0; i < 3; i++) rd(0, 8'hB2, 8'h60 + i);
		cmp(indBlock, 2);
		wr(0, 8'h10, 8'h5A);
		// Reset again in mid-run: every register returns to zero
		@(posedge clk) reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		rd(0, 8'hF8, 0);
		rd(0, 8'hB0, 0);
		cmp(indOffset, 0);
		cmp(indBlock, 0);
		wrapUp;
	end
endmodule : i2c_port_alias_indirect_access_tb_top
bind i2c_port_alias_indirect_access alias_access_props props (.*);
